// ==== fir_pkg.sv ====
package fir_pkg;

    localparam int COEF_W      = 8;
    localparam int SAMPLE_W    = 8;
    localparam int ACC_W       = 26;
    localparam int CELL_COUNT  = 8;
    localparam int ADDR_W      = 3;
    // low bits of the output buffer lost on each shift-and-add pass
    localparam int BUF_DROP_W  = 8;
    localparam int RESULT_LO_W = 16;

    // {decim_sel_hi, decim_sel_lo}: extra clocks a coefficient spends in a cell
    localparam logic [1:0] DECIM_NONE  = 2'h0;
    localparam logic [1:0] DECIM_ONE   = 2'h1;
    localparam logic [1:0] DECIM_TWO   = 2'h2;
    localparam logic [1:0] DECIM_THREE = 2'h3;

endpackage

// ==== fir_mac_cell.sv ====
`timescale 1ns/100ps
module fir_mac_cell #(
    parameter int COEF_W   = fir_pkg::COEF_W,
    parameter int SAMPLE_W = fir_pkg::SAMPLE_W,
    parameter int ACC_W    = fir_pkg::ACC_W
) (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic [COEF_W-1:0]   coef_in,
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire logic                coef_load,
    input  wire logic [1:0]          decim_sel,
    input  wire logic                clr_regs,
    input  wire logic                clr_acc,
    input  wire logic                cell_select,
    output logic      [COEF_W-1:0]   coef_out,
    output logic      [ACC_W-1:0]    acc,
    output logic      [ACC_W-1:0]    cell_hold_reg
);

    localparam int PROD_W = COEF_W + SAMPLE_W;

    logic        [COEF_W-1:0] coef_reg;
    logic        [COEF_W-1:0] decim_reg1;
    logic        [COEF_W-1:0] decim_reg2;
    logic        [COEF_W-1:0] decim_reg3;
    logic signed [PROD_W-1:0] product;
    logic signed [PROD_W-1:0] mult_pipe_stage0;
    logic signed [PROD_W-1:0] mult_pipe_stage1;
    logic        [ACC_W-1:0]  prod_wide;
    logic        [ACC_W-1:0]  next_acc;

    assign product   = $signed(coef_reg) * $signed(sample);
    assign prod_wide = {{(ACC_W-PROD_W){mult_pipe_stage1[PROD_W-1]}}, mult_pipe_stage1};
    assign next_acc  = acc + prod_wide;

    // coefficient and decimation registers share the load enable and clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            coef_reg   <= '0;
            decim_reg1 <= '0;
            decim_reg2 <= '0;
            decim_reg3 <= '0;
        end else if (clr_regs) begin
            coef_reg   <= '0;
            decim_reg1 <= '0;
            decim_reg2 <= '0;
            decim_reg3 <= '0;
        end else if (coef_load) begin
            coef_reg   <= coef_in;
            decim_reg1 <= coef_reg;
            decim_reg2 <= decim_reg1;
            decim_reg3 <= decim_reg2;
        end
    end

    always_comb begin
        case (decim_sel)
            fir_pkg::DECIM_ONE:   coef_out = decim_reg1;
            fir_pkg::DECIM_TWO:   coef_out = decim_reg2;
            fir_pkg::DECIM_THREE: coef_out = decim_reg3;
            default:              coef_out = coef_reg;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mult_pipe_stage0 <= '0;
            mult_pipe_stage1 <= '0;
        end else if (clr_regs) begin
            mult_pipe_stage0 <= '0;
            mult_pipe_stage1 <= '0;
        end else begin
            mult_pipe_stage0 <= product;
            mult_pipe_stage1 <= mult_pipe_stage0;
        end
    end

    // a plain reset leaves the accumulator running
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            acc <= '0;
        end else if (clr_acc) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end

    // keeps the finished sum while the accumulator restarts
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cell_hold_reg <= '0;
        end else if (clr_regs) begin
            cell_hold_reg <= '0;
        end else if (!cell_select) begin
            cell_hold_reg <= next_acc;
        end
    end

    a_mult_two_stage: assert property (@(posedge clock) disable iff (sys_rst)
        (!clr_regs [*2] ##1 !clr_acc) |=> (acc == ACC_W'($past(acc) + {{(ACC_W-PROD_W){$past(product[PROD_W-1], 3)}},
                                                                    $past(product, 3)})))
        else $error("product not accumulated three clocks later");

    a_hold_frozen: assert property (@(posedge clock) disable iff (sys_rst)
        (cell_select && !clr_regs) |=> $stable(cell_hold_reg))
        else $error("holding register changed while cell selected");

    a_coef_frozen: assert property (@(posedge clock) disable iff (sys_rst)
        (!coef_load && !clr_regs) |=> ($stable(coef_reg) && $stable(decim_reg3)))
        else $error("coefficient moved without load enable");

    a_acc_cleared: assert property (@(posedge clock) disable iff (sys_rst)
        clr_acc |=> (acc == '0))
        else $error("accumulator not cleared");

    a_acc_loads: assert property (@(posedge clock) disable iff (sys_rst)
        !clr_acc |=> (acc == $past(next_acc)))
        else $error("accumulator skipped adder output");

    a_hold_loads: assert property (@(posedge clock) disable iff (sys_rst)
        (!cell_select && !clr_regs) |=> (cell_hold_reg == $past(next_acc)))
        else $error("holding register missed adder output");

endmodule

// ==== fir_output_stage.sv ====
`timescale 1ns/100ps
module fir_output_stage #(
    parameter int ACC_W  = fir_pkg::ACC_W,
    parameter int DROP_W = fir_pkg::BUF_DROP_W
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             clr_regs,
    input  wire logic             shift_add,
    input  wire logic [ACC_W-1:0] cell_result,
    output logic      [ACC_W-1:0] result_data
);

    logic             shift_add_prev;
    logic [ACC_W-1:0] out_buffer;
    logic [ACC_W-1:0] feedback;
    logic [ACC_W-1:0] next_buffer;

    // zero mux: low shift_add starts a fresh sum
    assign feedback    = shift_add ? {{DROP_W{out_buffer[ACC_W-1]}}, out_buffer[ACC_W-1:DROP_W]} : '0;
    assign next_buffer = cell_result + feedback;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            out_buffer     <= '0;
            shift_add_prev <= 1'b0;
            result_data    <= '0;
        end else if (clr_regs) begin
            out_buffer     <= '0;
            shift_add_prev <= 1'b0;
            result_data    <= '0;
        end else begin
            out_buffer     <= next_buffer;
            shift_add_prev <= shift_add;
            // the mux remembers the previous select
            result_data    <= (!shift_add && !shift_add_prev) ? cell_result : out_buffer;
        end
    end

    a_shift_add_sum: assert property (@(posedge clock) disable iff (sys_rst)
        (shift_add && !clr_regs) |=> (out_buffer == ACC_W'($past(cell_result)
            + {{DROP_W{$past(out_buffer[ACC_W-1])}}, $past(out_buffer[ACC_W-1:DROP_W])})))
        else $error("shift-and-add sum wrong");

    a_zero_mux: assert property (@(posedge clock) disable iff (sys_rst)
        (!shift_add && !clr_regs) |=> (out_buffer == $past(cell_result)))
        else $error("zero mux did not feed zeros");

    a_out_mux_buffer: assert property (@(posedge clock) disable iff (sys_rst)
        ((shift_add || shift_add_prev) && !clr_regs) |=> (result_data == $past(out_buffer)))
        else $error("output mux did not select buffer");

endmodule

// ==== eight_cell_fir_mac_array.sv ====
// Behaviour
// - eight cascaded cells, each multiplies 8x8 and accumulates into 26 bits
// - without decimation coefficient leaves cell one clock after entering
// - decimation selects add 1, 2 or 3 clocks of coefficient delay
// - cells chained left to right; last cell output gated to pins
// - coefficient load enable latched; loads on second clock after going low
// - coefficient and decimation registers hold while load enable high
// - reset clears coefficient and decimation registers, latched like load enable
// - sample register loads on second clock after sample enable low
// - sample register loads zeros while sample enable high
// - two multiplier pipeline stages; sign-extended product added to accumulator
// - holding register loads each clock except while its cell is selected
// - accumulator loads adder output unless cleared
// - erase/reset table: reset clears all but accumulators, erase one, both everything
// - erase and reset together clear all accumulators on second clock
// - erase clears the addressed accumulator on second clock
// - output adder adds cell result to upper 18 buffer bits each clock
// - shift-add select picks zeros or buffer bits; latched one clock
// - cell result on bus only if select low now and previously
// - unchanged address keeps result from first clock of selection
// - low enable drives bits 0-15, high enable bits 16-25
// - cell address latched one clock before output use
// - enable high puts its result group in high impedance; here it only raises result_hi_oe_n or result_lo_oe_n, result_bus stays driven
`timescale 1ns/100ps
module eight_cell_fir_mac_array #(
    parameter int CELL_COUNT = fir_pkg::CELL_COUNT,
    parameter int COEF_W     = fir_pkg::COEF_W,
    parameter int SAMPLE_W   = fir_pkg::SAMPLE_W,
    parameter int ACC_W      = fir_pkg::ACC_W,
    parameter int ADDR_W     = fir_pkg::ADDR_W
) (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic [COEF_W-1:0]   coef_in,
    input  wire logic                coef_load_en_n,
    input  wire logic                decim_sel_lo,
    input  wire logic                decim_sel_hi,
    input  wire logic                coef_out_pin_en,
    output logic      [COEF_W-1:0]   coef_out,
    output logic                     coef_out_oe_n,
    input  wire logic [SAMPLE_W-1:0] sample_in,
    input  wire logic                sample_load_en_n,
    input  wire logic [ADDR_W-1:0]   cell_addr,
    input  wire logic                shift_add_sel,
    input  wire logic                filter_reset_n,
    input  wire logic                erase_n,
    input  wire logic                result_hi_en_n,
    input  wire logic                result_lo_en_n,
    output logic      [ACC_W-1:0]    result_bus,
    output logic                     result_hi_oe_n,
    output logic                     result_lo_oe_n
);

    logic                coef_load;
    logic                sample_load;
    logic                reset_q;
    logic                erase_q;
    logic                shift_add_q;
    logic [ADDR_W-1:0]   addr_q;
    logic [SAMPLE_W-1:0] sample_reg;
    logic [1:0]          decim_sel;
    logic [CELL_COUNT-1:0] cell_select;
    logic [CELL_COUNT-1:0] clr_acc;
    logic [COEF_W-1:0]   coef_chain [CELL_COUNT+1];
    logic [ACC_W-1:0]    cell_acc [CELL_COUNT];
    logic [ACC_W-1:0]    cell_hold [CELL_COUNT];
    logic [ACC_W-1:0]    cell_result;
    logic [ACC_W-1:0]    result_data;
    logic                acc_nonzero;

    assign decim_sel = {decim_sel_hi, decim_sel_lo};

    // load, sample, reset, erase, shift-add and address pins are latched one clock, which gives the two-clock load latency
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            coef_load   <= 1'b0;
            sample_load <= 1'b0;
            reset_q     <= 1'b0;
            erase_q     <= 1'b0;
            shift_add_q <= 1'b0;
            addr_q      <= '0;
        end else begin
            coef_load   <= !coef_load_en_n;
            sample_load <= !sample_load_en_n;
            reset_q     <= !filter_reset_n;
            erase_q     <= !erase_n;
            shift_add_q <= shift_add_sel;
            addr_q      <= cell_addr;
        end
    end

    // sample is broadcast to all cells; idle input feeds zeros so accumulators rest
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sample_reg <= '0;
        end else if (reset_q) begin
            sample_reg <= '0;
        end else if (sample_load) begin
            sample_reg <= sample_in;
        end else begin
            sample_reg <= '0;
        end
    end

    assign coef_chain[0] = coef_in;

    generate
        for (genvar i = 0; i < CELL_COUNT; i++) begin : g_cell
            assign cell_select[i] = (addr_q == ADDR_W'(i));
            // erase alone hits the addressed cell, erase with reset hits them all
            assign clr_acc[i] = erase_q && (reset_q || cell_select[i]);

            fir_mac_cell #(
                .COEF_W   (COEF_W),
                .SAMPLE_W (SAMPLE_W),
                .ACC_W    (ACC_W)
            ) u_cell (
                .clock         (clock),
                .sys_rst       (sys_rst),
                .coef_in       (coef_chain[i]),
                .sample        (sample_reg),
                .coef_load     (coef_load),
                .decim_sel     (decim_sel),
                .clr_regs      (reset_q),
                .clr_acc       (clr_acc[i]),
                .cell_select   (cell_select[i]),
                .coef_out      (coef_chain[i+1]),
                .acc           (cell_acc[i]),
                .cell_hold_reg (cell_hold[i])
            );

            // without decimation each link adds exactly one register stage
            a_chain_link: assert property (@(posedge clock) disable iff (sys_rst)
                (coef_load && !reset_q && (decim_sel == fir_pkg::DECIM_NONE)) |=>
                    ((decim_sel == fir_pkg::DECIM_NONE) -> (coef_chain[i+1] == $past(coef_chain[i]))))
                else $error("coefficient did not pass to next cell");
        end
    endgenerate

    // the holding register stops loading once selected, so the first value sticks
    assign cell_result = cell_hold[addr_q];

    fir_output_stage #(
        .ACC_W  (ACC_W),
        .DROP_W (fir_pkg::BUF_DROP_W)
    ) u_output (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .clr_regs    (reset_q),
        .shift_add   (shift_add_q),
        .cell_result (cell_result),
        .result_data (result_data)
    );

    assign coef_out       = coef_chain[CELL_COUNT];
    assign coef_out_oe_n  = !coef_out_pin_en;
    assign result_bus     = result_data;
    assign result_lo_oe_n = result_lo_en_n;
    assign result_hi_oe_n = result_hi_en_n;

    // assertion helper: any accumulator still holding a value
    always_comb begin
        acc_nonzero = 1'b0;
        for (int k = 0; k < CELL_COUNT; k++) begin
            acc_nonzero = acc_nonzero | (|cell_acc[k]);
        end
    end

    a_sample_latency: assert property (@(posedge clock) disable iff (sys_rst)
        (!sample_load_en_n && filter_reset_n) |=> ##1 (sample_reg == $past(sample_in)))
        else $error("sample not loaded on second clock");

    a_sample_zero_fill: assert property (@(posedge clock) disable iff (sys_rst)
        sample_load_en_n |=> ##1 (sample_reg == '0))
        else $error("sample register not zeroed while disabled");

    a_coef_latency: assert property (@(posedge clock) disable iff (sys_rst)
        (!coef_load_en_n && filter_reset_n) |=> ##1
            ((decim_sel == fir_pkg::DECIM_NONE) -> (coef_chain[1] == $past(coef_in))))
        else $error("coefficient not loaded on second clock");

    a_coef_frozen_pins: assert property (@(posedge clock) disable iff (sys_rst)
        (coef_load_en_n && filter_reset_n) |=> ##1 ($stable(decim_sel) -> $stable(coef_chain[1])))
        else $error("coefficient moved while load disabled");

    a_reset_clears: assert property (@(posedge clock) disable iff (sys_rst)
        !filter_reset_n |=> ##1 ((coef_chain[1] == '0) && (sample_reg == '0) && (result_data == '0)))
        else $error("reset did not clear registers");

    a_erase_all: assert property (@(posedge clock) disable iff (sys_rst)
        (!erase_n && !filter_reset_n) |=> ##1 !acc_nonzero)
        else $error("erase with reset left an accumulator set");

    a_erase_one: assert property (@(posedge clock) disable iff (sys_rst)
        !erase_n |=> ##1 (cell_acc[$past(cell_addr, 2)] == '0))
        else $error("addressed accumulator not erased");

    a_out_mux_cell: assert property (@(posedge clock) disable iff (sys_rst)
        (!shift_add_sel ##1 (!shift_add_sel && filter_reset_n)) |=> ##1 (result_data == $past(cell_result)))
        else $error("bus did not carry cell result");

    a_result_held: assert property (@(posedge clock) disable iff (sys_rst)
        ($stable(addr_q) && !$past(reset_q)) |-> $stable(cell_result))
        else $error("selected result changed while address steady");

    a_decim_one: assert property (@(posedge clock) disable iff (sys_rst)
        (coef_load && !reset_q) [*2] |=>
            ((decim_sel == fir_pkg::DECIM_ONE) -> (coef_chain[1] == $past(coef_in, 2))))
        else $error("one-clock decimation delay wrong");

    a_addr_latched: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |-> (addr_q == $past(cell_addr)))
        else $error("cell address not delayed one clock");

    a_shift_latched: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |-> (shift_add_q == $past(shift_add_sel)))
        else $error("shift-add select not delayed one clock");

    // plain reset must still flush the shared sample register
    a_sample_reset: assert property (@(posedge clock) disable iff (sys_rst)
        reset_q |=> (sample_reg == '0))
        else $error("reset left sample register loaded");

    a_select_onehot: assert property (@(posedge clock) disable iff (sys_rst)
        $onehot(cell_select) && cell_select[addr_q])
        else $error("cell decode not one-hot");

    a_bus_groups: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(result_hi_en_n) |-> (result_hi_oe_n && (result_lo_oe_n == result_lo_en_n)))
        else $error("result group enables crossed");

endmodule

// ==== fir_host_model.sv ====
`timescale 1ns/100ps
module fir_host_model (
    input  wire logic                     clock,
    input  wire logic [fir_pkg::ACC_W-1:0] result_bus,
    input  wire logic                     result_hi_oe_n,
    input  wire logic                     result_lo_oe_n,
    input  wire logic [7:0]               coef_out,
    input  wire logic                     coef_out_oe_n,
    output logic      [fir_pkg::ACC_W-1:0] seen_result,
    output logic      [7:0]               seen_coef
);
    // a released group shows the inverse of its last value, so it toggles each clock and shows the stale data again every second clock
    // no initialiser: the clocked process below is the only driver
    logic [fir_pkg::ACC_W-1:0] last_result;
    logic [7:0]                last_coef;

    always_ff @(posedge clock) begin
        last_result <= seen_result;
        last_coef   <= seen_coef;
    end

    always_comb begin
        seen_result[15:0]  = result_lo_oe_n ? ~last_result[15:0] : result_bus[15:0];
        seen_result[25:16] = result_hi_oe_n ? ~last_result[25:16] : result_bus[25:16];
        seen_coef          = coef_out_oe_n ? ~last_coef : coef_out;
    end
endmodule

// ==== tb_eight_cell_fir_mac_array.sv ====
`timescale 1ns/100ps
module tb_eight_cell_fir_mac_array;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  coef_in = 8'h00;
    logic        coef_load_en_n = 1'b1;
    logic        decim_sel_lo = 1'b0;
    logic        decim_sel_hi = 1'b0;
    logic        coef_out_pin_en = 1'b1;
    logic [7:0]  sample_in = 8'h00;
    logic        sample_load_en_n = 1'b1;
    logic [2:0]  cell_addr = 3'h0;
    logic        shift_add_sel = 1'b0;
    logic        filter_reset_n = 1'b1;
    logic        erase_n = 1'b1;
    logic        result_hi_en_n = 1'b0;
    logic        result_lo_en_n = 1'b0;
    logic [7:0]  coef_out;
    logic        coef_out_oe_n;
    logic [25:0] result_bus;
    logic        result_hi_oe_n;
    logic        result_lo_oe_n;
    logic [25:0] seen_result;
    logic [7:0]  seen_coef;
    int          fails = 0;
    int          checked = 0;
    int          lat[4];
    int          d;

    always #5 clock = ~clock;

    eight_cell_fir_mac_array dut_u (
        .clock(clock), .sys_rst(sys_rst), .coef_in(coef_in), .coef_load_en_n(coef_load_en_n),
        .decim_sel_lo(decim_sel_lo), .decim_sel_hi(decim_sel_hi), .coef_out_pin_en(coef_out_pin_en),
        .coef_out(coef_out), .coef_out_oe_n(coef_out_oe_n), .sample_in(sample_in),
        .sample_load_en_n(sample_load_en_n), .cell_addr(cell_addr), .shift_add_sel(shift_add_sel),
        .filter_reset_n(filter_reset_n), .erase_n(erase_n), .result_hi_en_n(result_hi_en_n),
        .result_lo_en_n(result_lo_en_n), .result_bus(result_bus), .result_hi_oe_n(result_hi_oe_n),
        .result_lo_oe_n(result_lo_oe_n)
    );

    fir_host_model host_u (
        .clock(clock), .result_bus(result_bus), .result_hi_oe_n(result_hi_oe_n),
        .result_lo_oe_n(result_lo_oe_n), .coef_out(coef_out), .coef_out_oe_n(coef_out_oe_n),
        .seen_result(seen_result), .seen_coef(seen_coef)
    );

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic end_sim;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_res(input logic [25:0] got, input logic [25:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: result got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_coef(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: coefficient got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask

    // enable goes low together with the value and stays low for 40 clocks, so the chain fills with one value
    task automatic load_coef(input logic [7:0] c);
        coef_in = c;
        coef_load_en_n = 1'b0;
        cyc(40);
        coef_load_en_n = 1'b1;
        cyc(2);
    endtask

    // n low cycles give exactly n loads; the sample is held through the cycle after the last one
    task automatic load_samples(input logic [7:0] x, input int n);
        sample_in = x;
        sample_load_en_n = 1'b0;
        cyc(n);
        sample_load_en_n = 1'b1;
        cyc(1);
        sample_in = 8'h00;
        cyc(8);
    endtask

    // stepping off the cell first lets its holding register take the accumulator again
    task automatic rd(input logic [2:0] k, input logic [25:0] exp);
        cell_addr = k ^ 3'h1;
        cyc(3);
        cell_addr = k;
        cyc(4);
        chk_res(seen_result, exp);
    endtask

    initial begin
        cyc(20);
        sys_rst = 1'b0;
        cyc(2);
        chk_res(result_bus, 26'h0000000);
        chk_coef(coef_out, 8'h00);
        load_coef(8'h03);
        coef_in = 8'h55;
        cyc(20);
        chk_coef(seen_coef, 8'h03);
        load_samples(8'hFB, 4);
        for (d = 0; d < 8; d++) begin
            rd(d[2:0], 26'h3FFFFC4);
        end
        rd(3'h5, 26'h3FFFFC4);
        load_samples(8'hFB, 4);
        chk_res(seen_result, 26'h3FFFFC4);
        rd(3'h5, 26'h3FFFF88);
        result_hi_en_n = 1'b1;
        cyc(1);
        chk_bit(result_hi_oe_n, 1'b1);
        chk_res(seen_result & 26'h000FFFF, 26'h000FF88);
        result_hi_en_n = 1'b0;
        result_lo_en_n = 1'b1;
        cyc(1);
        chk_bit(result_lo_oe_n, 1'b1);
        chk_res(seen_result & 26'h3FF0000, 26'h3FF0000);
        result_lo_en_n = 1'b0;
        cell_addr = 3'h2;
        cyc(2);
        erase_n = 1'b0;
        cyc(1);
        erase_n = 1'b1;
        cyc(3);
        rd(3'h2, 26'h0000000);
        rd(3'h3, 26'h3FFFF88);
        filter_reset_n = 1'b0;
        cyc(2);
        filter_reset_n = 1'b1;
        cyc(3);
        chk_coef(seen_coef, 8'h00);
        rd(3'h3, 26'h3FFFF88);
        filter_reset_n = 1'b0;
        erase_n = 1'b0;
        cyc(2);
        filter_reset_n = 1'b1;
        erase_n = 1'b1;
        cyc(3);
        rd(3'h3, 26'h0000000);
        rd(3'h6, 26'h0000000);
        load_coef(8'h10);
        load_samples(8'h10, 1);
        rd(3'h4, 26'h0000100);
        shift_add_sel = 1'b1;
        cyc(6);
        chk_res(seen_result, 26'h0000101);
        shift_add_sel = 1'b0;
        cyc(4);
        chk_res(seen_result, 26'h0000100);
        coef_out_pin_en = 1'b0;
        cyc(1);
        chk_bit(coef_out_oe_n, 1'b1);
        coef_out_pin_en = 1'b1;
        for (d = 0; d < 4; d++) begin
            {decim_sel_hi, decim_sel_lo} = d[1:0];
            coef_in = 8'h11;
            coef_load_en_n = 1'b0;
            cyc(45);
            coef_in = 8'h22;
            lat[d] = 0;
            while (seen_coef !== 8'h22 && lat[d] < 100) begin
                cyc(1);
                lat[d]++;
            end
            if (lat[d] >= 100) begin
                fails++;
                $display("mismatch at %0t: coefficient never left the chain", $time);
                end_sim();
            end
        end
        chk_bit(lat[0] == 8, 1'b1);
        for (d = 1; d < 4; d++) begin
            chk_bit(lat[d] - lat[0] == 8 * d, 1'b1);
        end
        end_sim();
    end
endmodule
